/* pla_lane_status.sv */
// Lane lock, marker checking, lane map and PCS status with APB registers.
//
// Design decisions made here: the register offsets and register access over APB.
`timescale 1ns/1ps
module pla_lane_status
	import pla_pkg::*;
(
	input  wire logic              core_clk_in,             // 10 MHz clock.
	input  wire logic              rst_in,                  // Async reset.
	input  wire logic              rx_reset_in,             // Receive reset.
	input  wire logic              tx_reset_in,             // Transmit reset.
	input  wire logic [LANES-1:0]  rx_block_lock_in,        // Word lock.
	input  wire logic [LANES-1:0]  rx_word_valid_in,        // Word strobe.
	input  wire logic [LANES-1:0]  rx_marker_valid_in,      // Marker seen.
	input  wire logic [LANES-1:0]  rx_marker_bad_in,        // Malformed.
	input  wire logic [7:0]        rx_marker_id_in,         // Ids, 2 bits each.
	input  wire logic [LANES-1:0]  rx_bip_mismatch_in,      // BIP8 mismatch.
	input  wire logic              rx_hi_ber_in,            // High BER state.
	input  wire logic              tx_init_state_in,        // Encoder in init.
	input  wire logic              tx_fifo_under_in,        // FIFO underflow.
	input  wire logic              tx_fifo_over_in,         // FIFO overflow.
	input  wire logic              psel,                    // APB select.
	input  wire logic              penable,                 // APB enable.
	input  wire logic              pwrite,                  // APB direction.
	input  wire logic [11:0]       paddr,                   // APB address.
	input  wire logic [31:0]       pwdata,                  // APB write data.
	output logic                   pready,                  // APB ready.
	output logic [31:0]            prdata,                  // APB read data.
	output logic                   pslverr,                 // APB error.
	output logic                   rx_misaligned_out,       // Misalign pulse.
	output logic                   rx_aligned_out,          // All aligned.
	output logic                   rx_status_out,           // PCS status.
	output logic [LANES-1:0]       rx_lane_marker_found_out,// Demuxed lanes.
	output logic [LANES-1:0]       rx_lane_lock_vector_out, // Lane sync.
	output logic [LANES-1:0]       rx_sync_err_out,         // Sync errors.
	output logic [LANES-1:0]       rx_marker_spacing_err_out, // Pulses.
	output logic [LANES-1:0]       rx_marker_repeat_err_out,  // Pulses.
	output logic                   rx_marker_format_err_out,  // Pulse.
	output logic [LANES-1:0]       rx_bip_err_out,          // BIP8 pulses.
	output logic [1:0]             rx_lane0_phys_map_out,   // PCS lane 0.
	output logic [1:0]             rx_lane1_phys_map_out,   // PCS lane 1.
	output logic [1:0]             rx_lane2_phys_map_out,   // PCS lane 2.
	output logic [1:0]             rx_lane3_phys_map_out,   // PCS lane 3.
	output logic                   tx_local_fault_out,      // Init state.
	output logic                   tx_fifo_err_out,         // FIFO error.
	output logic [LOOP_W-1:0]      xcvr_loopback_sel_out    // Loopback sel.
);

	// Registered configuration and bus answer.
	logic [SPC_W-1:0]  spacing_m1;          // Marker spacing minus one.
	logic [SPC_W-1:0]  next_spacing_m1;     // Next spacing.
	logic [LOOP_W-1:0] next_loop;           // Next loopback select.
	logic              next_pready;         // Next ready.
	logic [31:0]       next_prdata;         // Next read data.
	logic              next_pslverr;        // Next error flag.

	// Per physical lane state, built in the generate loop below except good_marker.
	logic [LANES-1:0]  seen;                // Marker received since lock.
	logic [LANES-1:0]  phys_synced;         // Lock and marker on phys lane.
	logic [LANES-1:0]  next_sync_err;       // Next sync error levels.
	logic [LANES-1:0]  next_len_err;        // Next spacing pulses.
	logic [LANES-1:0]  next_rep_err;        // Next repeat pulses.
	logic [LANES-1:0]  next_bip;            // Next parity pulses.
	logic [LANES-1:0]  good_marker;         // Well formed marker per lane.

	// Alignment and map state.
	logic              all_seen;            // All lanes marked together once.
	logic              next_all_seen;       // Next of the above.
	logic              next_misaligned;     // Next misalign pulse.
	logic              next_aligned;        // Next aligned level.
	logic              next_status;         // Next PCS status.
	logic [1:0]        lane_map [LANES];    // Physical lane per PCS lane.
	logic [1:0]        next_map [LANES];    // Next map.
	logic [LANES-1:0]  next_found;          // Next marker found bits.
	logic [LANES-1:0]  next_lockv;          // Next lock vector.
	logic              next_fmt_err;        // Next format pulse.
	logic              next_tx_fault;       // Next local fault.
	logic              next_fifo_err;       // Next FIFO error.

	assign good_marker = rx_marker_valid_in & ~rx_marker_bad_in;

	// Marker checking per physical lane; pulses fire only while locked.
	genvar g;
	generate
		for (g = 0; g < LANES; g++) begin : g_lane
			logic [SPC_W-1:0] cnt;           // Words since last marker.
			logic [SPC_W-1:0] next_cnt;      // Next word count.
			logic [2:0]       run;           // Marker errors in a row.
			logic [2:0]       next_run;      // Next run length.
			logic             next_seen;     // Next marker seen flag.
			logic             was_lock;      // Lock one cycle ago.
			logic             miss;          // Marker overdue.
			logic             bad;           // Marker error this word.

			// A missing marker is declared after twice the spacing, so a
			// single corrupted marker does not flag a sync error.
			always_comb begin
				next_cnt = cnt;
				next_run = run;
				next_seen = seen[g];
				next_len_err[g] = 1'b0;
				next_rep_err[g] = 1'b0;
				next_bip[g] = 1'b0;
				next_sync_err[g] = rx_sync_err_out[g];
				miss = ({1'b0, cnt} >= {spacing_m1, 1'b1});
				bad = 1'b0;
				if (rx_reset_in || !rx_block_lock_in[g]) begin
					// Lock loss after lock counts as sync error.
					next_cnt = '0;
					next_run = '0;
					next_seen = 1'b0;
					next_sync_err[g] = !rx_reset_in &&
					                   (was_lock || rx_sync_err_out[g]);
				end else if (rx_marker_valid_in[g]) begin
					next_cnt = '0;
					if (rx_marker_bad_in[g]) begin
						bad = 1'b1;
					end else begin
						next_seen = 1'b1;
						next_sync_err[g] = 1'b0;
					end
					if (seen[g] && cnt != spacing_m1) begin
						next_len_err[g] = 1'b1;
						bad = 1'b1;
					end
					next_bip[g] = rx_bip_mismatch_in[g] && seen[g];
					if (!bad) begin
						next_run = '0;
					end else if (run == REPEAT_MAX - 3'h1) begin
						next_rep_err[g] = 1'b1;
						next_run = '0;
					end else begin
						next_run = run + 3'h1;
					end
				end else if (rx_word_valid_in[g]) begin
					if (!miss) begin
						next_cnt = cnt + 16'h0001;
					end else begin
						next_sync_err[g] = 1'b1;
					end
				end
			end

			// Registers of one lane.
			always_ff @(posedge core_clk_in or posedge rst_in) begin
				if (rst_in) begin
					cnt <= '0;
					run <= '0;
					seen[g] <= 1'b0;
					was_lock <= 1'b0;
					rx_sync_err_out[g] <= 1'b0;
					rx_marker_spacing_err_out[g] <= 1'b0;
					rx_marker_repeat_err_out[g] <= 1'b0;
					rx_bip_err_out[g] <= 1'b0;
				end else begin
					cnt <= next_cnt;
					run <= next_run;
					seen[g] <= next_seen;
					was_lock <= rx_block_lock_in[g] && !rx_reset_in;
					rx_sync_err_out[g] <= next_sync_err[g];
					rx_marker_spacing_err_out[g] <= next_len_err[g];
					rx_marker_repeat_err_out[g] <= next_rep_err[g];
					rx_bip_err_out[g] <= next_bip[g];
				end
			end

			assign phys_synced[g] = rx_block_lock_in[g] && seen[g];
		end
	endgenerate

	// Alignment, lane map and status. The map is written by marker id, so
	// two lanes with the same id leave the higher physical lane in place.
	always_comb begin
		next_all_seen = all_seen;
		next_misaligned = 1'b0;
		next_aligned = rx_aligned_out;
		next_map = lane_map;
		next_found = rx_lane_marker_found_out;
		next_lockv = '0;
		next_fmt_err = 1'b0;
		for (int p = 0; p < LANES; p++) begin
			if (good_marker[p] && rx_block_lock_in[p]) begin
				next_map[rx_marker_id_in[2*p +: 2]] = p[1:0];
				next_found[rx_marker_id_in[2*p +: 2]] = 1'b1;
			end
		end
		for (int l = 0; l < LANES; l++) begin
			if (!rx_block_lock_in[next_map[l]]) begin
				next_found[l] = 1'b0;
			end
			// The code is only trusted while this bit is high.
			next_lockv[l] = next_found[l] && phys_synced[next_map[l]];
		end
		next_fmt_err = |(rx_marker_valid_in & rx_marker_bad_in &
		                 rx_block_lock_in);
		if (&rx_marker_valid_in) begin
			next_all_seen = 1'b1;
		end
		if (all_seen && |rx_marker_valid_in && !(&rx_marker_valid_in)) begin
			next_misaligned = 1'b1;
		end
		if (next_misaligned || !(&next_lockv)) begin
			next_aligned = 1'b0;
		end else if (&good_marker) begin
			next_aligned = 1'b1;
		end
		if (rx_reset_in) begin
			next_all_seen = 1'b0;
			next_misaligned = 1'b0;
			next_aligned = 1'b0;
			next_found = '0;
			next_lockv = '0;
			next_fmt_err = 1'b0;
		end
		next_status = next_aligned && !rx_hi_ber_in;
	end

	// Receive status registers.
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			all_seen <= 1'b0;
			rx_misaligned_out <= 1'b0;
			rx_aligned_out <= 1'b0;
			rx_status_out <= 1'b0;
			rx_lane_marker_found_out <= '0;
			rx_lane_lock_vector_out <= '0;
			rx_marker_format_err_out <= 1'b0;
			lane_map <= '{default: 2'h0};
		end else begin
			all_seen <= next_all_seen;
			rx_misaligned_out <= next_misaligned;
			rx_aligned_out <= next_aligned;
			rx_status_out <= next_status;
			rx_lane_marker_found_out <= next_found;
			rx_lane_lock_vector_out <= next_lockv;
			rx_marker_format_err_out <= next_fmt_err;
			lane_map <= next_map;
		end
	end

	assign rx_lane0_phys_map_out = lane_map[0];
	assign rx_lane1_phys_map_out = lane_map[1];
	assign rx_lane2_phys_map_out = lane_map[2];
	assign rx_lane3_phys_map_out = lane_map[3];

	// Transmit indicators. The FIFO error is sticky because recovery needs
	// a port reset anyway; a fresh event in the reset cycle still wins.
	always_comb begin
		next_tx_fault = tx_init_state_in && !tx_reset_in;
		next_fifo_err = tx_fifo_err_out && !tx_reset_in;
		if (tx_fifo_under_in || tx_fifo_over_in) begin
			next_fifo_err = 1'b1;
		end
	end

	// Transmit registers.
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			tx_local_fault_out <= 1'b0;
			tx_fifo_err_out <= 1'b0;
		end else begin
			tx_local_fault_out <= next_tx_fault;
			tx_fifo_err_out <= next_fifo_err;
		end
	end

	// APB slave: the setup cycle prepares the answer, so the access phase
	// always lasts one cycle. Read data is sampled at setup time.
	always_comb begin
		next_pready = psel && !penable;
		next_prdata = '0;
		next_pslverr = 1'b0;
		next_spacing_m1 = spacing_m1;
		next_loop = xcvr_loopback_sel_out;
		if (psel && !penable) begin
			case (paddr)
				OFS_CTRL: next_prdata[SPC_W-1:0] = spacing_m1;
				OFS_LOOP: next_prdata[LOOP_W-1:0] = xcvr_loopback_sel_out;
				OFS_STATUS: begin
					next_prdata[ST_ALIGNED] = rx_aligned_out;
					next_prdata[ST_PCS_OK] = rx_status_out;
					next_prdata[ST_TX_FAULT] = tx_local_fault_out;
					next_prdata[ST_FIFO_ERR] = tx_fifo_err_out;
					next_prdata[ST_FOUND +: LANES] = rx_lane_marker_found_out;
					next_prdata[ST_LOCK +: LANES] = rx_lane_lock_vector_out;
					next_prdata[ST_SYNC_ERR +: LANES] = rx_sync_err_out;
				end
				OFS_MAP: begin
					for (int l = 0; l < LANES; l++) begin
						next_prdata[2*l +: 2] = lane_map[l];
					end
				end
				default: next_pslverr = 1'b1;
			endcase
			// Status and map are read only; writes to them are refused.
			if (pwrite && (paddr == OFS_STATUS || paddr == OFS_MAP)) begin
				next_pslverr = 1'b1;
			end
			if (pwrite) begin
				next_prdata = '0;
			end
		end
		if (psel && penable && pready && pwrite) begin
			if (paddr == OFS_CTRL) begin
				next_spacing_m1 = pwdata[SPC_W-1:0];
			end
			if (paddr == OFS_LOOP) begin
				next_loop = pwdata[LOOP_W-1:0];
			end
		end
	end

	// Bus and configuration registers.
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			pready <= 1'b0;
			prdata <= '0;
			pslverr <= 1'b0;
			spacing_m1 <= SPC_RST;
			xcvr_loopback_sel_out <= LOOP_RST;
		end else begin
			pready <= next_pready;
			prdata <= next_prdata;
			pslverr <= next_pslverr;
			spacing_m1 <= next_spacing_m1;
			xcvr_loopback_sel_out <= next_loop;
		end
	end

endmodule : pla_lane_status

/* pla_pkg.sv */
// Constants and register layout of the PCS lane alignment status block.
package pla_pkg;
	localparam int          LANES       = 4;              // Lane_count_param.
	localparam int          SPC_W       = 16;             // Spacing width.
	localparam int          LOOP_W      = 12;             // Loopback width.
	localparam logic [2:0]  REPEAT_MAX  = 3'h4;           // Errors in a row.
	localparam logic [15:0] SPC_RST     = 16'h3fff;       // Spacing reset.
	localparam logic [11:0] LOOP_RST    = 12'h000;        // Loopback reset.
	localparam logic [11:0] OFS_CTRL    = 12'h000;        // Spacing register.
	localparam logic [11:0] OFS_LOOP    = 12'h004;        // Loopback register.
	localparam logic [11:0] OFS_STATUS  = 12'h008;        // Status register.
	localparam logic [11:0] OFS_MAP     = 12'h00c;        // Lane map register.
	localparam int          ST_ALIGNED  = 0;              // Status bit.
	localparam int          ST_PCS_OK   = 1;              // Status bit.
	localparam int          ST_TX_FAULT = 2;              // Status bit.
	localparam int          ST_FIFO_ERR = 3;              // Status bit.
	localparam int          ST_FOUND    = 4;              // Found field base.
	localparam int          ST_LOCK     = 8;              // Lock field base.
	localparam int          ST_SYNC_ERR = 12;             // Sync error base.
endpackage : pla_pkg

/* pla_chk.sv */
// Concurrent checks on the lane alignment status block ports.
`timescale 1ns/1ps
module pla_chk
	import pla_pkg::*;
(
	input wire logic             core_clk_in,             // Clock.
	input wire logic             rst_in,                  // Reset.
	input wire logic             rx_reset_in,             // Rx reset.
	input wire logic             tx_reset_in,             // Tx reset.
	input wire logic [LANES-1:0] rx_block_lock_in,        // Lock.
	input wire logic [LANES-1:0] rx_marker_valid_in,      // Markers.
	input wire logic [LANES-1:0] rx_bip_mismatch_in,      // Parity.
	input wire logic             rx_hi_ber_in,            // High BER.
	input wire logic             tx_init_state_in,        // Init.
	input wire logic             tx_fifo_under_in,        // Under.
	input wire logic             tx_fifo_over_in,         // Over.
	input wire logic             rx_misaligned_out,       // Pulse.
	input wire logic             rx_aligned_out,          // Level.
	input wire logic             rx_status_out,           // Level.
	input wire logic [LANES-1:0] rx_lane_lock_vector_out, // Level.
	input wire logic [LANES-1:0] rx_bip_err_out,          // Pulses.
	input wire logic             tx_local_fault_out,      // Level.
	input wire logic             tx_fifo_err_out          // Sticky.
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (rst_in);
	logic seen_all;      // Markers seen on all lanes at once.
	logic next_seen_all; // Next value.
	// A receive reset forgets the first alignment, so the gate closes again.
	always_comb next_seen_all = !rx_reset_in && (seen_all || &rx_marker_valid_in);
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) seen_all <= 1'b0;
		else seen_all <= next_seen_all;
	end
	misalign_gate_a: assert property (rx_misaligned_out |-> seen_all)
		else $error("misalignment before first full marker set");
	status_cause_a: assert property (rx_status_out |->
		rx_aligned_out && !$past(rx_hi_ber_in)) else $error("status high wrongly");
	aligned_lock_a: assert property (rx_aligned_out |->
		$past(&rx_block_lock_in)) else $error("aligned without lock");
	bip_cause_a: assert property (|rx_bip_err_out |->
		|$past(rx_bip_mismatch_in & rx_marker_valid_in)) else $error("bip");
	fault_follow_a: assert property (!tx_reset_in |=>
		tx_local_fault_out == $past(tx_init_state_in)) else $error("fault");
	fifo_set_a: assert property (tx_fifo_under_in || tx_fifo_over_in
		|=> tx_fifo_err_out) else $error("fifo error not set");
	fifo_hold_a: assert property (tx_fifo_err_out && !tx_reset_in
		|=> tx_fifo_err_out) else $error("fifo error dropped");
	rx_clear_a: assert property (rx_reset_in |=> !rx_aligned_out &&
		!rx_status_out && rx_lane_lock_vector_out == '0) else $error("rx reset");
	cover property (rx_misaligned_out);
	cover property (rx_status_out);
	cover property (|rx_bip_err_out);
endmodule : pla_chk
bind pla_lane_status pla_chk u_chk (.*);

/* pla_far_end.sv */
// Behavioural far end: four serial lanes sending words and lane markers.
`timescale 1ns/1ps
module pla_far_end
	import pla_pkg::*;
(
	input  wire logic             clk_in,   // Clock.
	input  wire logic             en_in,    // Lanes running.
	input  wire logic [15:0]      gap_in,   // Words between markers.
	input  wire logic [1:0]       key_in,   // Lane id scramble.
	input  wire logic [LANES-1:0] bad_in,   // Corrupt markers.
	input  wire logic [LANES-1:0] bip_in,   // Corrupt parity.
	input  wire logic [LANES-1:0] late_in,  // Stretch one gap.
	output logic      [LANES-1:0] lock_out, // Word lock.
	output logic      [LANES-1:0] word_out, // Data word.
	output logic      [LANES-1:0] mark_out, // Marker word.
	output logic      [LANES-1:0] bad_out,  // Malformed flag.
	output logic      [7:0]       id_out,   // Marker ids.
	output logic      [LANES-1:0] bip_out   // Parity flag.
);
	logic [15:0] wc [LANES]; // Words since the last marker.
	logic        m;          // Marker due on this lane.
	initial {lock_out, word_out, mark_out, bad_out, bip_out, id_out} = '0;
	// Marker-only fields toggle between markers so stale data never passes.
	always @(posedge clk_in) begin
		for (int p = 0; p < LANES; p++) begin
			m = en_in && wc[p] >= gap_in + 16'(late_in[p]);
			lock_out[p] <= en_in;
			mark_out[p] <= m;
			word_out[p] <= en_in && !m;
			bad_out[p] <= m ? bad_in[p] : wc[p][0];
			bip_out[p] <= m ? bip_in[p] : wc[p][1];
			id_out[2*p+:2] <= m ? 2'(p) ^ key_in : ~wc[p][1:0];
			if (!en_in) wc[p] <= gap_in;
			else wc[p] <= m ? 16'h0 : wc[p] + 16'h1;
		end
	end
endmodule : pla_far_end

/* pla_lane_status_tb_top.sv */
// Self-checking bench for the PCS lane alignment status block.
`timescale 1ns/1ps
module pla_lane_status_tb_top;
	import pla_pkg::*;
	localparam logic [15:0] GAP = 16'h0007; // Short marker spacing.
	logic core_clk_in = 1'b0, rst_in = 1'b1, rx_reset_in = 1'b0;
	logic tx_reset_in = 1'b0, rx_hi_ber_in = 1'b0, tx_init_state_in = 1'b0;
	logic tx_fifo_under_in = 1'b0, tx_fifo_over_in = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata;
	logic [LANES-1:0] rx_block_lock_in, rx_word_valid_in, rx_marker_valid_in;
	logic [LANES-1:0] rx_marker_bad_in, rx_bip_mismatch_in, rx_sync_err_out;
	logic [7:0] rx_marker_id_in;
	logic pready, pslverr, rx_misaligned_out, rx_aligned_out, rx_status_out;
	logic rx_marker_format_err_out, tx_local_fault_out, tx_fifo_err_out;
	logic [LANES-1:0] rx_lane_marker_found_out, rx_lane_lock_vector_out;
	logic [LANES-1:0] rx_marker_spacing_err_out, rx_marker_repeat_err_out;
	logic [LANES-1:0] rx_bip_err_out;
	logic [1:0] rx_lane0_phys_map_out, rx_lane1_phys_map_out;
	logic [1:0] rx_lane2_phys_map_out, rx_lane3_phys_map_out;
	logic [LOOP_W-1:0] xcvr_loopback_sel_out;
	logic en = 1'b0;
	logic [1:0] key = 2'h0;
	logic [LANES-1:0] bad = '0, bip = '0, late = '0;
	int error_cnt = 0, n_checks = 0, cyc = 0;
	int c_mis = 0, c_sp = 0, c_rep = 0, c_fmt = 0, c_bip = 0;
	pla_lane_status DUT (.*);
	pla_far_end u_far (.clk_in(core_clk_in), .en_in(en), .gap_in(GAP),
		.key_in(key), .bad_in(bad), .bip_in(bip), .late_in(late),
		.lock_out(rx_block_lock_in), .word_out(rx_word_valid_in),
		.mark_out(rx_marker_valid_in), .bad_out(rx_marker_bad_in),
		.id_out(rx_marker_id_in), .bip_out(rx_bip_mismatch_in));
	initial forever #50 core_clk_in = ~core_clk_in;
	// Pulses are tallied mid-cycle, well away from the launching edge.
	always @(negedge core_clk_in) begin
		c_mis += int'(rx_misaligned_out);
		c_sp += int'(|rx_marker_spacing_err_out);
		c_rep += int'(|rx_marker_repeat_err_out);
		c_fmt += int'(rx_marker_format_err_out);
		c_bip += int'(|rx_bip_err_out);
	end
	// Cuts a hang short; the whole run needs well under a thousand cycles.
	always @(posedge core_clk_in) begin
		cyc++;
		if (cyc == 5000) begin
			error_cnt++;
			results();
		end
	end
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk_in);
	endtask : tick
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// PCS lane l rides on physical lane l xor key, packed as the map register.
	function automatic logic [7:0] exp_map(input logic [1:0] k);
		return {k ^ 2'h3, k ^ 2'h2, k ^ 2'h1, k};
	endfunction : exp_map
	// One APB transfer; an idle edge follows so psel is never set twice.
	// The wait has no limit of its own; the bench timeout ends a hang.
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk_in) penable <= 1'b1;
		do begin
			@(posedge core_clk_in);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		tick(1);
	endtask : apb
	task automatic clr();
		{c_mis, c_sp, c_rep, c_fmt, c_bip} = '0;
	endtask : clr
	task automatic results();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : results
	initial begin
		logic [31:0] r;
		logic e;
		logic [11:0] lb;
		r = $urandom(32'h005a);
		tick(16);
		rst_in <= 1'b0;
		tick(1);
		apb(1'b0, OFS_CTRL, 32'h0, r, e);
		chk(r, {16'h0, SPC_RST});
		apb(1'b0, 12'h010, 32'h0, r, e);
		chk({e, r[30:0]}, 32'h80000000);
		apb(1'b1, OFS_STATUS, 32'hffffffff, r, e);
		chk(32'(e), 32'h1);
		lb = 12'($urandom);
		apb(1'b1, OFS_CTRL, {16'h0, GAP}, r, e);
		apb(1'b1, OFS_LOOP, {20'h0, lb}, r, e);
		apb(1'b0, OFS_LOOP, 32'h0, r, e);
		chk(r, {20'h0, lb});
		chk(32'(xcvr_loopback_sel_out), 32'(lb));
		key <= 2'($urandom);
		en <= 1'b1;
		tick(40);
		chk({rx_aligned_out, rx_status_out}, 2'h3);
		chk({rx_lane_marker_found_out, rx_lane_lock_vector_out}, 8'hff);
		chk({rx_lane3_phys_map_out, rx_lane2_phys_map_out,
			rx_lane1_phys_map_out, rx_lane0_phys_map_out}, exp_map(key));
		apb(1'b0, OFS_STATUS, 32'h0, r, e);
		chk(r, (32'h3 << ST_ALIGNED) | (32'hf << ST_FOUND) |
			(32'hf << ST_LOCK));
		apb(1'b0, OFS_MAP, 32'h0, r, e);
		chk(r, 32'(exp_map(key)));
		rx_hi_ber_in <= 1'b1;
		tick(3);
		chk({rx_aligned_out, rx_status_out}, 2'h2);
		rx_hi_ber_in <= 1'b0;
		clr();
		bip <= 4'h2;
		tick(8);
		bip <= 4'h0;
		tick(4);
		chk(c_bip, 1);
		clr();
		bad <= 4'h1;
		tick(32);
		bad <= 4'h0;
		tick(4);
		chk(c_fmt, 4);
		chk(c_rep, 1);
		tick(16);
		clr();
		late <= 4'h4;
		tick(8);
		late <= 4'h0;
		tick(16);
		chk(32'(c_mis > 0), 1);
		chk(32'(c_sp > 0), 1);
		en <= 1'b0;
		tick(3);
		chk({rx_aligned_out, rx_status_out, rx_lane_lock_vector_out}, 0);
		chk(32'(rx_sync_err_out != 4'h0), 1);
		// Forget the first alignment, then restart with lane 2 one word
		// behind: markers never meet on all lanes, so no pulse may follow.
		rx_reset_in <= 1'b1;
		tick(2);
		rx_reset_in <= 1'b0;
		clr();
		late <= 4'h4;
		en <= 1'b1;
		tick(2);
		late <= 4'h0;
		tick(24);
		chk(c_mis, 0);
		en <= 1'b0;
		tick(2);
		en <= 1'b1;
		tick(40);
		clr();
		rx_reset_in <= 1'b1;
		tick(3);
		chk({rx_aligned_out, rx_lane_marker_found_out}, 5'h0);
		rx_reset_in <= 1'b0;
		tick(40);
		chk({rx_aligned_out, 31'(c_mis)}, 32'h80000000);
		repeat (8) begin
			tx_init_state_in <= 1'($urandom);
			tick(2);
			chk(tx_local_fault_out, tx_init_state_in);
		end
		for (int i = 0; i < 2; i++) begin
			{tx_fifo_over_in, tx_fifo_under_in} <= (i == 1) ? 2'h2 : 2'h1;
			tick(1);
			{tx_fifo_over_in, tx_fifo_under_in} <= 2'h0;
			tick(4);
			chk(tx_fifo_err_out, 1'b1);
			tx_reset_in <= 1'b1;
			tick(3);
			chk({tx_fifo_err_out, tx_local_fault_out}, 2'h0);
			tx_reset_in <= 1'b0;
		end
		results();
	end
endmodule : pla_lane_status_tb_top
